// ==== hw/link_cmd_handler.v ====
/*
 * Command handler of an input device on a daisy-chained serial link.
 * Assumes a frame receiver delivering one frame per rx_valid pulse with an
 * error flag, and a transmitter taking frames on tx_valid/tx_ready.
 */
// Functional notes
// - In hold mode, link-clear leaves hold mode and is sent on unchanged.
// - In hold mode, soft-link-reset is executed as normal.
// - In hold mode, all other commands are dropped silently.
// - Outside hold mode, link-clear is simply sent on.
// - Opcodes 30h-FBh: sent on unchanged, whether supported or not.
// - Auto-address 08h: enter hold mode, send config-address-error.
// - Poll with nothing pending: clear repeat buffer, resend poll.
// - Low four bits count frames on link; room is 15 minus count.
// - Pending and room: copy record to repeat buffer, send it, poll plus record length.
// - Repeat-poll with empty buffer: resend the command.
// - Repeat-poll, buffer not empty, room: send buffer then opcode plus buffer length.
// - Repeat-poll without room: resend unchanged, keep buffer.
// - FCh or FDh: enter hold mode and resend the command.
// - FEh or FFh: enter hold mode and send transmit-error.
// - Hard reset is caught inside the link controller itself.
// - Link-clear keeps address and flags, only leaves hold mode.
// - Enter-forward: if addressed to this device, switch to forward mode, then resend.
// - After enter-forward, chain end returns nothing; host sees chain end.
// - Enter-return: if addressed to this device, switch to return mode before resending.
// - Device address lies in 1..7 and selects exactly one device.
// - Parity/framing error: enter hold mode, send transmit-error unless held.
// - In hold mode, data frames are discarded.
// - Soft reset: forward, resend, then return mode and hold mode.
`default_nettype none
`include "link_cmd_regs.vh"
module link_cmd_handler #(
	parameter DEPTH = `REC_DEPTH
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire rx_valid,
	input wire [11:0] rx_frame,
	input wire rx_error,
	output reg tx_valid,
	output reg [11:0] tx_frame,
	input wire tx_ready,
	output reg forward_mode,
	output reg startup_hold_mode
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	localparam [3:0] S_IDLE = 4'b0001;
	localparam [3:0] S_SEND = 4'b0010;
	localparam [3:0] S_LAST = 4'b0100;
	localparam [3:0] S_DONE = 4'b1000;
	reg [3:0] state;
	reg [2:0] dev_addr;
	reg support_ext;
	reg [7:0] rec [0:DEPTH-1];
	reg [7:0] rep [0:DEPTH-1];
	reg [3:0] rec_len;
	reg [3:0] rep_len;
	reg [3:0] idx;
	reg from_rep;
	reg [11:0] final_frame;
	reg after_soft; // Soft reset tail pending
	reg [7:0] cmd_count;
	integer i;
	wire cmd = rx_frame[`FRM_CMD_BIT];
	wire [2:0] faddr = rx_frame[`FRM_ADDR_HI:`FRM_ADDR_LO];
	wire [7:0] op = rx_frame[7:0];
	wire hit = (faddr == dev_addr) && (dev_addr != 3'h0);
	// Free room on the link for a given opcode
	function [3:0] room;
		input [7:0] o;
		begin
			room = `ROOM_MAX - o[3:0];
		end
	endfunction
	// Build a command frame with given address and opcode
	function [11:0] cmdf;
		input [2:0] a;
		input [7:0] o;
		begin
			cmdf = {1'b1, a, o};
		end
	endfunction
	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Reads are muxed at access start, writes land with the pready edge
	wire apb_acc = psel && penable && !pready;
	wire apb_wr = psel && penable && pready && pwrite;
	// Register write side and read mux
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			support_ext <= 1'b0;
		end else begin
			pready <= apb_acc;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			if (apb_wr && paddr == `REG_CTRL)
				support_ext <= pwdata[`CTRL_SUPPORT_BIT];
			if (apb_acc) begin
				case (paddr)
				`REG_CTRL: prdata <= {31'h0, support_ext};
				`REG_STATUS: prdata <= {24'h0, 1'b0, dev_addr,
					rep_len != 4'h0, rec_len != 4'h0,
					forward_mode, startup_hold_mode};
				`REG_DATA: prdata <= 32'h00000000;
				`REG_LEN: prdata <= {20'h0, cmd_count, rec_len};
				default: pslverr <= 1'b1;
				endcase
			end
		end
	end
	// ----------------------------------------
	// Command engine
	// ----------------------------------------
	// Frame handling, record load and transmit sequencing
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
			startup_hold_mode <= 1'b1;
			forward_mode <= 1'b0;
			dev_addr <= 3'h0;
			rec_len <= 4'h0;
			rep_len <= 4'h0;
			idx <= 4'h0;
			from_rep <= 1'b0;
			final_frame <= 12'h000;
			tx_valid <= 1'b0;
			tx_frame <= 12'h000;
			after_soft <= 1'b0;
			cmd_count <= 8'h00;
		end else begin
			// Software appends record bytes while engine idle
			if (apb_wr && paddr == `REG_DATA && state == S_IDLE &&
				rec_len != DEPTH[3:0]) begin
				rec[rec_len] <= pwdata[7:0];
				rec_len <= rec_len + 4'h1;
			end
			case (state)
			S_IDLE: begin
				if (rx_valid) begin
					if (rx_error) begin
						if (!startup_hold_mode) begin
							final_frame <= cmdf(dev_addr,
								`OP_TRANSMIT_ERROR);
							state <= S_LAST;
						end
						startup_hold_mode <= 1'b1;
					end else if (!cmd) begin
						// Data frames unused here; dropped in hold too
						state <= S_IDLE;
					end else if (startup_hold_mode &&
						op == `OP_LINK_CLEAR) begin
						startup_hold_mode <= 1'b0;
						final_frame <= rx_frame;
						state <= S_LAST;
					end else if (startup_hold_mode &&
						op != `OP_SOFT_RESET) begin
						state <= S_IDLE;
					end else begin
						cmd_count <= cmd_count + 8'h01;
						final_frame <= rx_frame;
						state <= S_LAST;
						if (op == `OP_SOFT_RESET) begin
							forward_mode <= 1'b1;
							after_soft <= 1'b1;
						end else if (op == `OP_ENTER_FORWARD) begin
							if (hit)
								forward_mode <= 1'b1;
						end else if (op == `OP_ENTER_RETURN) begin
							if (hit)
								forward_mode <= 1'b0;
						end else if (op == `OP_AUTO_ADDR_OVF) begin
							startup_hold_mode <= 1'b1;
							final_frame <= cmdf(faddr,
								`OP_CONFIG_ADDR_ERROR);
						end else if (op[7:4] == 4'h0 &&
							op[3]) begin
							dev_addr <= op[2:0];
							final_frame <= cmdf(faddr, op + 8'h01);
						end else if (op[7:4] == 4'h1) begin
							if (rec_len == 4'h0) begin
								rep_len <= 4'h0;
							end else if (rec_len <= room(op)) begin
								for (i = 0; i < DEPTH; i = i + 1)
									rep[i] <= rec[i];
								rep_len <= rec_len;
								rec_len <= 4'h0; // Record reported
								from_rep <= 1'b1; // Sent from copy
								idx <= 4'h0;
								final_frame <= cmdf(faddr,
									op + {4'h0, rec_len});
								state <= S_SEND;
							end // else resend unchanged
						end else if (op[7:4] == 4'h2) begin
							if (rep_len != 4'h0 &&
								rep_len <= room(op)) begin
								from_rep <= 1'b1;
								idx <= 4'h0;
								final_frame <= cmdf(faddr,
									op + {4'h0, rep_len});
								state <= S_SEND;
							end // resend, keep buffer
						end else if (op == `OP_TRANSMIT_ERROR ||
							op == `OP_CONFIG_ADDR_ERROR) begin
							startup_hold_mode <= 1'b1;
						end else if (op == `OP_HARD_RESET ||
							op == `OP_PROHIBITED) begin
							startup_hold_mode <= 1'b1;
							final_frame <= cmdf(faddr,
								`OP_TRANSMIT_ERROR);
						end else if (op >= 8'h30 && support_ext) begin
							final_frame <= rx_frame;
						end // link-clear and others resent
					end
				end
			end
			S_SEND: begin
				if (!tx_valid || tx_ready) begin
					tx_valid <= 1'b1;
					tx_frame <= {1'b0, dev_addr,
						from_rep ? rep[idx] : rec[idx]};
					idx <= idx + 4'h1;
					if (idx + 4'h1 == (from_rep ? rep_len : rec_len))
						state <= S_LAST;
				end
			end
			S_LAST: begin
				if (!tx_valid || tx_ready) begin
					tx_valid <= 1'b1;
					tx_frame <= final_frame;
					state <= S_DONE;
				end
			end
			S_DONE: begin
				if (tx_ready) begin
					tx_valid <= 1'b0;
					from_rep <= 1'b0;
					if (after_soft) begin
						forward_mode <= 1'b0;
						startup_hold_mode <= 1'b1;
						after_soft <= 1'b0;
					end
					state <= S_IDLE;
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule // link_cmd_handler
`default_nettype wire

// ==== hw/link_cmd_regs.vh ====
/*
 * Constants for the input link device command handler: opcodes, frame
 * layout, APB register offsets and field positions.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef LINK_CMD_REGS_VH
`define LINK_CMD_REGS_VH
// ----------------------------------------
// Frame layout
// ----------------------------------------
`define FRM_W 12
`define FRM_CMD_BIT 11
`define FRM_ADDR_HI 10
`define FRM_ADDR_LO 8
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_LINK_CLEAR 8'h00
`define OP_ENTER_FORWARD 8'h01
`define OP_ENTER_RETURN 8'h02
`define OP_SOFT_RESET 8'h04
`define OP_AUTO_ADDR_OVF 8'h08
`define OP_TRANSMIT_ERROR 8'hfc
`define OP_CONFIG_ADDR_ERROR 8'hfd
`define OP_HARD_RESET 8'hfe
`define OP_PROHIBITED 8'hff
`define ROOM_MAX 4'hf
// ----------------------------------------
// APB register byte offsets
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_DATA 12'h008
`define REG_LEN 12'h00c
// CTRL fields
`define CTRL_SUPPORT_BIT 0
`define CTRL_PUSH_BIT 1
// STATUS fields
`define ST_HOLD_BIT 0
`define ST_FWD_BIT 1
`define ST_PEND_BIT 2
`define ST_REPEAT_POLL_CMD_BIT 3
`define ST_ADDR_LO 4
`define REC_DEPTH 15
`endif

// ==== test/link_cmd_handler_sva.sv ====
/* Port checker for the link command handler.
   Assumes binding onto link_cmd_handler, one clock, reset low. */
`default_nettype none
module link_cmd_handler_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rx_valid,
	input wire logic [11:0] rx_frame,
	input wire logic rx_error,
	input wire logic tx_valid,
	input wire logic [11:0] tx_frame,
	input wire logic tx_ready,
	input wire logic forward_mode,
	input wire logic startup_hold_mode
);
	timeunit 1ns;
	timeprecision 1ns;
	logic prev_tx;
	wire quiet = !tx_valid && !prev_tx;
	wire rx_cmd = rx_valid && quiet && rx_frame[11] && !rx_error;
	wire tx_cmd = tx_valid && tx_frame[11];
	// --------------------------------
	// Helper and properties
	// --------------------------------
	// Engine idle for two cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prev_tx <= 1'b0;
		else
			prev_tx <= tx_valid;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_apb_answer: assert property (psel && penable && !pready |=> pready)
		else $error("no apb answer");
	a_ready_once: assert property (pready |=> !pready)
		else $error("pready too long");
	a_tx_stands: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_frame)) else $error("tx frame dropped");
	a_fwd_first: assert property (tx_cmd && tx_frame[7:0] == 8'h01 |->
		forward_mode) else $error("forward late");
	a_ret_first: assert property (tx_cmd && tx_frame[7:0] == 8'h02 |->
		!forward_mode) else $error("return late");
	a_soft_fwd: assert property (tx_cmd && tx_frame[7:0] == 8'h04 |->
		forward_mode) else $error("soft reset not forwarded");
	a_hold_drop: assert property (rx_cmd && startup_hold_mode &&
		rx_frame[7:0] == 8'h30 |=> !tx_valid [*4])
		else $error("held command sent");
	a_err_hold: assert property (rx_cmd && rx_frame[7:1] == 7'h7e |->
		##[1:3] startup_hold_mode) else $error("no hold");
	a_ter_sent: assert property (rx_cmd && !startup_hold_mode &&
		rx_frame[7:1] == 7'h7f |-> ##[1:4] tx_valid &&
		tx_frame[7:0] == 8'hfc) else $error("no transmit error");
	c_data: cover property (tx_valid && tx_ready && !tx_frame[11]);
	c_unmapped: cover property (pready && pslverr);
	c_forward: cover property ($rose(forward_mode));
endmodule // link_cmd_handler_chk
bind link_cmd_handler link_cmd_handler_chk u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .rx_valid(rx_valid), .rx_frame(rx_frame),
	.rx_error(rx_error), .tx_valid(tx_valid), .tx_frame(tx_frame),
	.tx_ready(tx_ready), .forward_mode(forward_mode),
	.startup_hold_mode(startup_hold_mode));
`default_nettype wire

// ==== test/link_peer.sv ====
/* Far side of the link: frame source and stalling frame sink.
   Assumes the bench calls send and reads got. */
`default_nettype none
module link_peer (
	input wire logic pclk,
	input wire logic tx_valid,
	input wire logic [11:0] tx_frame,
	output var logic tx_ready = 1'b0,
	output var logic rx_valid = 1'b0,
	output var logic [11:0] rx_frame = 12'h000,
	output var logic rx_error = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic slow = 1'b0;
	logic [8:0] got [$];
	// Collect accepted frames, stall every other cycle when slow
	always @(posedge pclk) begin
		if (tx_valid && tx_ready)
			got.push_back({tx_frame[11], tx_frame[7:0]});
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end
	// One frame pulse, then a scrambled idle value
	task send(input logic [11:0] f, input logic e);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_frame <= f;
		rx_error <= e;
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_frame <= ~f;
		rx_error <= 1'b0;
	endtask
endmodule // link_peer
`default_nettype wire

// ==== test/tb_input_link_device_command_handler.sv ====
/* Bench for the link command handler.
   Assumes link_peer as far side and APB access to the registers. */
`default_nettype none
module tb_input_link_device_command_handler;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, tx_valid, tx_ready, rx_valid;
	logic rx_error, forward_mode, startup_hold_mode, er;
	logic [11:0] paddr = 12'h000, rx_frame, tx_frame;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	int mismatches = 0, checked = 0;
	link_cmd_handler u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid(rx_valid), .rx_frame(rx_frame),
		.rx_error(rx_error), .tx_valid(tx_valid), .tx_frame(tx_frame),
		.tx_ready(tx_ready), .forward_mode(forward_mode),
		.startup_hold_mode(startup_hold_mode));
	link_peer u_peer (.pclk(pclk), .tx_valid(tx_valid),
		.tx_frame(tx_frame), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_frame(rx_frame), .rx_error(rx_error));
	always #20 pclk = ~pclk;
	// --------------------------------
	// Tasks
	// --------------------------------
	task end_of_test();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// One APB transfer, held until pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			chk(n, 0);
			end_of_test();
		end
	endtask
	// Send one frame, expect n frames back (first in low bits)
	task run(input logic [11:0] f, input logic e, input int n,
		input logic [35:0] x);
		int k;
		u_peer.got.delete();
		u_peer.send(f, e);
		k = 0;
		while (k < 200 && (n == 0 || u_peer.got.size() < n)) begin
			@(posedge pclk);
			k++;
		end
		repeat (4) @(posedge pclk);
		chk(u_peer.got.size(), n);
		for (int i = 0; i < n && i < u_peer.got.size(); i++)
			chk(u_peer.got[i], x[9*i +: 9]);
		if (n > 0 && k >= 200)
			end_of_test();
	endtask
	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		logic [7:0] ops [5] = '{8'hfc, 8'hfd, 8'hfe, 8'hff, 8'h08};
		logic [7:0] ans [5] = '{8'hfc, 8'hfd, 8'hfc, 8'hfc, 8'hfd};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h004, 32'h0);
		chk(rd[1:0], 2'b01);
		run(12'h830, 1'b0, 0, 36'h0);
		run(12'h800, 1'b0, 1, 36'h100);
		chk(startup_hold_mode, 1'b0);
		run(12'h809, 1'b0, 1, 36'h10a);
		run(12'h810, 1'b0, 1, 36'h110);
		apb(1'b1, 12'h008, 32'h000000a5);
		apb(1'b1, 12'h008, 32'h0000005a);
		run(12'h81f, 1'b0, 1, 36'h11f);
		run(12'h812, 1'b0, 3, {9'h114, 9'h05a, 9'h0a5});
		run(12'h82f, 1'b0, 1, 36'h12f);
		u_peer.slow <= 1'b1;
		run(12'h820, 1'b0, 3, {9'h122, 9'h05a, 9'h0a5});
		run(12'h810, 1'b0, 1, 36'h110);
		run(12'h820, 1'b0, 1, 36'h120);
		u_peer.slow <= 1'b0;
		run(12'h901, 1'b0, 1, 36'h101);
		chk(forward_mode, 1'b1);
		run(12'h902, 1'b0, 1, 36'h102);
		chk(forward_mode, 1'b0);
		run(12'h840, 1'b0, 1, 36'h140);
		apb(1'b1, 12'h000, 32'h1);
		run(12'h8fb, 1'b0, 1, 36'h1fb);
		apb(1'b0, 12'h010, 32'h0);
		chk(er, 1'b1);
		for (int i = 0; i < 5; i++) begin
			run({4'h8, ops[i]}, 1'b0, 1, {28'h1, ans[i]});
			chk(startup_hold_mode, 1'b1);
			run(12'h800, 1'b0, 1, 36'h100);
		end
		run(12'h8ab, 1'b1, 1, 36'h1fc);
		run(12'h8ab, 1'b1, 0, 36'h0);
		run(12'h0ab, 1'b0, 0, 36'h0);
		run(12'h804, 1'b0, 1, 36'h104);
		chk({forward_mode, startup_hold_mode}, 2'b01);
		run(12'h800, 1'b0, 1, 36'h100);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd[6:4], 3'h1);
		end_of_test();
	end
endmodule // tb_input_link_device_command_handler
`default_nettype wire
